// File: core/plcb_top.sv
// Low-power and break-state control of the PLL clock generator, with its register file.
//
// Functional notes
// RULE1: Generator keeps running, outputs unchanged, in wait.
// RULE2: Software drops source select before loop-on.
// RULE3: Loop stays on and interrupting during wait.
// RULE4: Stop forces crystal, base and loop interrupt outputs low.
// RULE5: Stop clears source select when VCO selected.
// RULE6: After stop, crystal halved; select stays clear.
// RULE7: Clear-enable set lets break-time clears work.
// RULE8: Flags cleared in break stay cleared.
// RULE9: Clear-enable low protects loop flag in break.
// RULE10: Auto mode sets tracking flag leaving acquisition.
// RULE11: Auto mode sets lock flag on tolerance.
// RULE12: Auto mode flags interrupt on every lock change.
// RULE13: Source change within three edges, output held.
// RULE14: Select needs loop on; loop-on kept while selected.
// RULE15: Break and clear-enable inputs gate flag clears.
`timescale 1ns/10ps
`default_nettype none
`include "plcb_regs.svh"
module plcb_top
    import plcb_pkg::*;
(
    input wire logic SYS_CLK_IN, // System clock, 20 MHz.
    input wire logic SYS_RST_IN, // Synchronous reset, high.
    input wire logic XTAL_CLK_IN, // Crystal clock level.
    input wire logic VCO_CLK_IN, // VCO clock level.
    input wire logic STOP_IN, // Stop mode, high while stopped.
    input wire logic WAIT_IN, // Wait mode, high while waiting.
    input wire logic BREAK_IN, // Break state from break module.
    input wire logic BREAK_CLEAR_EN_IN, // Break clear enable.
    input wire logic ACQ_DONE_IN, // Tracking tolerance met.
    input wire logic LOCK_MET_IN, // Lock tolerance met.
    output logic CRYSTAL_CLK_OUT, // Gated crystal clock.
    output logic BASE_CLK_OUT, // Base clock, source halved.
    output logic CLKGEN_IRQ_OUT, // Loop interrupt request.
    output logic VCO_LOOP_ON_OUT, // Loop enable to the VCO.
    output logic IRQ_OUT, // Status interrupt, level.
    input wire logic [7:0] S_AXI_AWADDR, // AXI write address.
    input wire logic S_AXI_AWVALID, // AXI write address valid.
    output logic S_AXI_AWREADY, // AXI write address ready.
    input wire logic [31:0] S_AXI_WDATA, // AXI write data.
    input wire logic [3:0] S_AXI_WSTRB, // AXI write strobes.
    input wire logic S_AXI_WVALID, // AXI write data valid.
    output logic S_AXI_WREADY, // AXI write data ready.
    output logic [1:0] S_AXI_BRESP, // AXI write response.
    output logic S_AXI_BVALID, // AXI write response valid.
    input wire logic S_AXI_BREADY, // AXI write response ready.
    input wire logic [7:0] S_AXI_ARADDR, // AXI read address.
    input wire logic S_AXI_ARVALID, // AXI read address valid.
    output logic S_AXI_ARREADY, // AXI read address ready.
    output logic [31:0] S_AXI_RDATA, // AXI read data.
    output logic [1:0] S_AXI_RRESP, // AXI read response.
    output logic S_AXI_RVALID, // AXI read valid.
    input wire logic S_AXI_RREADY // AXI read ready.
);
    localparam int EVN = `PLCB_EV_N;

    plcb_wr_s wr;
    logic rd_en, rd_hit, wr_hit;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    // Control and status state.
    logic irq_en, next_irq_en;
    logic loop_flag, next_loop_flag;
    logic loop_on, next_loop_on;
    logic src_sel, next_src_sel;
    logic auto_bw, next_auto_bw;
    logic manual_trk, next_manual_trk;
    logic trk_auto, next_trk_auto;
    logic lock_st, next_lock_st;
    logic stop_q, next_stop_q;
    logic xtal_gate, next_xtal_gate;
    logic [EVN-1:0] stat, next_stat;
    logic [EVN-1:0] stat_en, next_stat_en;
    logic [EVN-1:0] events;

    // Decoded strobes.
    logic clr_ok, stop_rise;
    logic wr_ctrl, wr_bw, wr_en, wr_clr;
    logic rd_ctrl;
    logic [7:0] wbyte;
    logic sw_busy;

    // Bus front end.
    plcb_axil u_axil (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .awaddr_in(S_AXI_AWADDR),
        .awvalid_in(S_AXI_AWVALID),
        .awready_out(S_AXI_AWREADY),
        .wdata_in(S_AXI_WDATA),
        .wstrb_in(S_AXI_WSTRB),
        .wvalid_in(S_AXI_WVALID),
        .wready_out(S_AXI_WREADY),
        .bresp_out(S_AXI_BRESP),
        .bvalid_out(S_AXI_BVALID),
        .bready_in(S_AXI_BREADY),
        .araddr_in(S_AXI_ARADDR),
        .arvalid_in(S_AXI_ARVALID),
        .arready_out(S_AXI_ARREADY),
        .rdata_out(S_AXI_RDATA),
        .rresp_out(S_AXI_RRESP),
        .rvalid_out(S_AXI_RVALID),
        .rready_in(S_AXI_RREADY),
        .wr_out(wr),
        .rd_en_out(rd_en),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_hit_in(rd_hit),
        .wr_hit_in(wr_hit)
    );

    // Base clock source switch, held still during changes.
    plcb_clk_switch u_switch (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .xtal_in(XTAL_CLK_IN),
        .vco_in(VCO_CLK_IN),
        .sel_in(src_sel), // RULE13
        .stop_in(STOP_IN), // RULE4
        .base_out(BASE_CLK_OUT),
        .busy_out(sw_busy)
    );

    // Address decode; only the low byte lane carries register bits.
    always_comb begin
        wbyte = wr.strb[0] ? wr.data[7:0] : 8'h00;
        wr_ctrl = wr.valid && wr.strb[0] && wr.addr == `PLCB_OFF_LOOP_CTRL;
        wr_bw = wr.valid && wr.strb[0] && wr.addr == `PLCB_OFF_LOOP_BW;
        wr_en = wr.valid && wr.strb[0] && wr.addr == `PLCB_OFF_IRQ_EN;
        wr_clr = wr.valid && wr.strb[0] && wr.addr == `PLCB_OFF_IRQ_CLR;
        wr_hit = wr.addr == `PLCB_OFF_LOOP_CTRL || wr.addr == `PLCB_OFF_LOOP_BW ||
                 wr.addr == `PLCB_OFF_IRQ_EN || wr.addr == `PLCB_OFF_IRQ_CLR;
        rd_ctrl = rd_en && rd_addr == `PLCB_OFF_LOOP_CTRL;
    end

    // Flag clears work outside break, or in break with clear-enable set.
    assign clr_ok = !BREAK_IN || BREAK_CLEAR_EN_IN; // RULE15 RULE7 RULE9
    assign stop_rise = STOP_IN && !stop_q;

    // Events that feed the sticky status register.
    always_comb begin
        events = '0;
        events[`PLCB_EV_TRACK] = next_trk_auto && !trk_auto; // RULE10
        events[`PLCB_EV_LOCK] = next_lock_st && !lock_st; // RULE11
        events[`PLCB_EV_STOP] = stop_rise;
    end

    // Read multiplexer; the loop flag and lock read as zero in manual mode.
    always_comb begin
        rd_data = 32'h0;
        rd_hit = 1'b1;
        unique case (rd_addr)
            `PLCB_OFF_LOOP_CTRL: begin
                rd_data[7:0] = `PLCB_CTRL_UNUSED;
                rd_data[`PLCB_CTRL_IRQ_EN_BIT] = irq_en;
                rd_data[`PLCB_CTRL_FLAG_BIT] = loop_flag && auto_bw;
                rd_data[`PLCB_CTRL_LOOP_ON_BIT] = loop_on;
                rd_data[`PLCB_CTRL_SRC_SEL_BIT] = src_sel;
            end
            `PLCB_OFF_LOOP_BW: begin
                rd_data[`PLCB_BW_AUTO_BIT] = auto_bw;
                rd_data[`PLCB_BW_LOCK_BIT] = lock_st;
                rd_data[`PLCB_BW_TRK_BIT] = auto_bw ? trk_auto : manual_trk;
            end
            `PLCB_OFF_IRQ_STAT: rd_data[EVN-1:0] = stat;
            `PLCB_OFF_IRQ_EN: rd_data[EVN-1:0] = stat_en;
            `PLCB_OFF_IRQ_CLR: rd_data = 32'h0;
            default: rd_hit = 1'b0;
        endcase
    end

    // Next values of the control and status state.
    always_comb begin
        next_irq_en = irq_en;
        next_loop_flag = loop_flag;
        next_loop_on = loop_on;
        next_src_sel = src_sel;
        next_auto_bw = auto_bw;
        next_manual_trk = manual_trk;
        next_stop_q = STOP_IN;
        next_stat_en = stat_en;
        next_stat = stat;
        // Wait mode gates nothing, so the generator and its interrupt keep running.
        next_xtal_gate = XTAL_CLK_IN && !STOP_IN; // RULE1 RULE4

        // Loop status tracks the analog detector only with the loop on in auto mode.
        next_trk_auto = auto_bw && loop_on && ACQ_DONE_IN; // RULE10
        next_lock_st = auto_bw && loop_on && LOCK_MET_IN; // RULE11 RULE3

        // Control register write with the select and loop-on interlock.
        if (wr_ctrl) begin
            next_irq_en = wbyte[`PLCB_CTRL_IRQ_EN_BIT];
            next_src_sel = wbyte[`PLCB_CTRL_SRC_SEL_BIT] && loop_on; // RULE14
            next_loop_on = wbyte[`PLCB_CTRL_LOOP_ON_BIT] || src_sel; // RULE14 RULE2
        end

        // Stop returns the base clock to the crystal; select stays clear afterwards.
        if (STOP_IN) begin
            next_src_sel = 1'b0; // RULE5 RULE6
        end

        // Bandwidth register; the manual tracking value is kept while auto runs.
        if (wr_bw) begin
            next_auto_bw = wbyte[`PLCB_BW_AUTO_BIT];
            if (!auto_bw) begin
                next_manual_trk = wbyte[`PLCB_BW_TRK_BIT];
            end
        end

        // Loop flag: cleared by a control read, set on lock change; set wins.
        if (rd_ctrl && clr_ok) begin
            next_loop_flag = 1'b0; // RULE9 RULE7 RULE8
        end
        if (!auto_bw) begin
            next_loop_flag = 1'b0;
        end else if (next_lock_st != lock_st) begin
            next_loop_flag = 1'b1; // RULE12
        end

        // Sticky status: write one to clear, gated in break; new events win.
        if (wr_en) begin
            next_stat_en = wbyte[EVN-1:0];
        end
        if (wr_clr && clr_ok) begin
            next_stat = stat & ~wbyte[EVN-1:0]; // RULE7 RULE8
        end
        next_stat = next_stat | events;
    end

    // Control and status registers.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            irq_en <= 1'b0;
            loop_flag <= 1'b0;
            loop_on <= `PLCB_RST_LOOP_ON;
            src_sel <= 1'b0;
            auto_bw <= 1'b0;
            manual_trk <= 1'b0;
            trk_auto <= 1'b0;
            lock_st <= 1'b0;
            stop_q <= 1'b0;
            xtal_gate <= 1'b0;
            stat <= '0;
            stat_en <= '0;
        end else begin
            irq_en <= next_irq_en;
            loop_flag <= next_loop_flag;
            loop_on <= next_loop_on;
            src_sel <= next_src_sel;
            auto_bw <= next_auto_bw;
            manual_trk <= next_manual_trk;
            trk_auto <= next_trk_auto;
            lock_st <= next_lock_st;
            stop_q <= next_stop_q;
            xtal_gate <= next_xtal_gate;
            stat <= next_stat;
            stat_en <= next_stat_en;
        end
    end

    // Outputs; the loop interrupt is masked at once by stop, not a cycle late.
    assign CRYSTAL_CLK_OUT = xtal_gate; // RULE4
    assign CLKGEN_IRQ_OUT = loop_flag && irq_en && auto_bw && !STOP_IN; // RULE4 RULE3
    assign VCO_LOOP_ON_OUT = loop_on; // RULE3
    assign IRQ_OUT = |(stat & stat_en);
endmodule
`default_nettype wire

// File: core/plcb_regs.svh
// Offsets, fields, reset values and timing counts of the clock block.
`ifndef PLCB_REGS_SVH
`define PLCB_REGS_SVH
`define PLCB_ADDR_W 8
`define PLCB_OFF_LOOP_CTRL 8'h00
`define PLCB_OFF_LOOP_BW 8'h04
`define PLCB_OFF_IRQ_STAT 8'h08
`define PLCB_OFF_IRQ_EN 8'h0c
`define PLCB_OFF_IRQ_CLR 8'h10
`define PLCB_CTRL_IRQ_EN_BIT 7
`define PLCB_CTRL_FLAG_BIT 6
`define PLCB_CTRL_LOOP_ON_BIT 5
`define PLCB_CTRL_SRC_SEL_BIT 4
`define PLCB_BW_AUTO_BIT 7
`define PLCB_BW_LOCK_BIT 6
`define PLCB_BW_TRK_BIT 5
`define PLCB_EV_TRACK 0
`define PLCB_EV_LOCK 1
`define PLCB_EV_STOP 2
`define PLCB_EV_N 3
`define PLCB_CTRL_UNUSED 8'h0f
`define PLCB_RST_LOOP_ON 1'b1
`define PLCB_SW_EDGES 2'h2
`define PLCB_RESP_OKAY 2'h0
`define PLCB_RESP_SLVERR 2'h2
`endif

// File: core/plcb_pkg.sv
// Types shared by the clock block's modules.
package plcb_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } plcb_wr_s;
    typedef enum logic {
        PLCB_SW_RUN = 1'b0,
        PLCB_SW_HOLD = 1'b1
    } plcb_sw_e;
endpackage

// File: core/plcb_axil.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/10ps
`default_nettype none
`include "plcb_regs.svh"
module plcb_axil
    import plcb_pkg::*;
(
    input wire logic clk_in, // System clock.
    input wire logic rst_in, // Synchronous reset, high.
    input wire logic [7:0] awaddr_in, // Write address.
    input wire logic awvalid_in, // Write address valid.
    output logic awready_out, // Write address ready.
    input wire logic [31:0] wdata_in, // Write data.
    input wire logic [3:0] wstrb_in, // Write byte strobes.
    input wire logic wvalid_in, // Write data valid.
    output logic wready_out, // Write data ready.
    output logic [1:0] bresp_out, // Write response.
    output logic bvalid_out, // Write response valid.
    input wire logic bready_in, // Write response ready.
    input wire logic [7:0] araddr_in, // Read address.
    input wire logic arvalid_in, // Read address valid.
    output logic arready_out, // Read address ready.
    output logic [31:0] rdata_out, // Read data.
    output logic [1:0] rresp_out, // Read response.
    output logic rvalid_out, // Read data valid.
    input wire logic rready_in, // Read data ready.
    output plcb_wr_s wr_out, // Register write strobe.
    output logic rd_en_out, // Register read strobe.
    output logic [7:0] rd_addr_out, // Register read address.
    input wire logic [31:0] rd_data_in, // Register read value.
    input wire logic rd_hit_in, // Read address is mapped.
    input wire logic wr_hit_in // Write address is mapped.
);
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0] addr, next_addr;
    logic [31:0] data, next_data, next_rdata;
    logic [3:0] strb, next_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;

    // Address and data are taken in either order and held until both are present.
    assign awready_out = !aw_held && !bvalid_out;
    assign wready_out = !w_held && !bvalid_out;
    assign arready_out = !rvalid_out;
    assign rd_en_out = arvalid_in && arready_out;
    assign rd_addr_out = araddr_in;
    assign wr_out = '{valid: aw_held && w_held && !bvalid_out, addr: addr, data: data, strb: strb};

    // Next channel state; a write fires in the same cycle that both halves are first held.
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_addr = addr;
        next_data = data;
        next_strb = strb;
        next_bvalid = bvalid_out;
        next_bresp = bresp_out;
        next_rvalid = rvalid_out;
        next_rdata = rdata_out;
        next_rresp = rresp_out;
        if (awvalid_in && awready_out) begin
            next_aw_held = 1'b1;
            next_addr = awaddr_in;
        end
        if (wvalid_in && wready_out) begin
            next_w_held = 1'b1;
            next_data = wdata_in;
            next_strb = wstrb_in;
        end
        if (wr_out.valid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit_in ? `PLCB_RESP_OKAY : `PLCB_RESP_SLVERR;
        end else if (bvalid_out && bready_in) begin
            next_bvalid = 1'b0;
        end
        if (rd_en_out) begin
            next_rvalid = 1'b1;
            next_rdata = rd_data_in;
            next_rresp = rd_hit_in ? `PLCB_RESP_OKAY : `PLCB_RESP_SLVERR;
        end else if (rvalid_out && rready_in) begin
            next_rvalid = 1'b0;
        end
    end

    // Channel state registers.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            addr <= 8'h00;
            data <= 32'h0;
            strb <= 4'h0;
            bvalid_out <= 1'b0;
            bresp_out <= 2'h0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0;
            rresp_out <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            addr <= next_addr;
            data <= next_data;
            strb <= next_strb;
            bvalid_out <= next_bvalid;
            bresp_out <= next_bresp;
            rvalid_out <= next_rvalid;
            rdata_out <= next_rdata;
            rresp_out <= next_rresp;
        end
    end
endmodule
`default_nettype wire

// File: core/plcb_clk_switch.sv
// Base clock source switch with a static hold during changeover and divide by two.
`timescale 1ns/10ps
`default_nettype none
`include "plcb_regs.svh"
module plcb_clk_switch
    import plcb_pkg::*;
(
    input wire logic clk_in, // System clock.
    input wire logic rst_in, // Synchronous reset, high.
    input wire logic xtal_in, // Crystal clock level.
    input wire logic vco_in, // VCO clock level.
    input wire logic sel_in, // Requested source, 1 selects VCO.
    input wire logic stop_in, // Stop mode level.
    output logic base_out, // Selected clock halved.
    output logic busy_out // Changeover in progress.
);
    plcb_sw_e state, next_state;
    logic xtal_q, vco_q, active, next_active, next_base;
    logic [1:0] xcnt, vcnt, next_xcnt, next_vcnt;
    logic xrise, vrise, src_rise;

    assign xrise = xtal_in && !xtal_q;
    assign vrise = vco_in && !vco_q;
    assign src_rise = active ? vrise : xrise;
    assign busy_out = (state == PLCB_SW_HOLD);

    // Hold the output still until both clocks have shown two edges, which
    // keeps the change within three edges of each and avoids a runt pulse.
    always_comb begin
        next_state = state;
        next_active = active;
        next_base = base_out;
        next_xcnt = xcnt;
        next_vcnt = vcnt;
        if (stop_in) begin
            next_state = PLCB_SW_RUN; // RULE4
            next_active = 1'b0; // RULE6
            next_base = 1'b0; // RULE4
        end else begin
            unique case (state)
                PLCB_SW_RUN: begin
                    if (sel_in != active) begin
                        next_state = PLCB_SW_HOLD; // RULE13
                        next_xcnt = 2'h0;
                        next_vcnt = 2'h0;
                    end else if (src_rise) begin
                        next_base = !base_out;
                    end
                end
                PLCB_SW_HOLD: begin
                    if (xrise && xcnt != `PLCB_SW_EDGES) next_xcnt = xcnt + 2'h1;
                    if (vrise && vcnt != `PLCB_SW_EDGES) next_vcnt = vcnt + 2'h1;
                    if (xcnt == `PLCB_SW_EDGES && vcnt == `PLCB_SW_EDGES) begin
                        next_state = PLCB_SW_RUN; // RULE13
                        next_active = sel_in;
                    end
                end
            endcase
        end
    end

    // Switch state registers.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= PLCB_SW_RUN;
            active <= 1'b0;
            base_out <= 1'b0;
            xcnt <= 2'h0;
            vcnt <= 2'h0;
            xtal_q <= 1'b0;
            vco_q <= 1'b0;
        end else begin
            state <= next_state;
            active <= next_active;
            base_out <= next_base;
            xcnt <= next_xcnt;
            vcnt <= next_vcnt;
            xtal_q <= xtal_in;
            vco_q <= vco_in;
        end
    end
endmodule
`default_nettype wire

// File: verif/plcb_chk_sva.sv
// Checker of stop, loop-enable and bus timing at the clock block's ports.
`timescale 1ns/10ps
`default_nettype none
module plcb_chk (
    input wire logic SYS_CLK_IN, // Clock.
    input wire logic SYS_RST_IN, // Reset.
    input wire logic XTAL_CLK_IN, // Crystal level.
    input wire logic STOP_IN, // Stop level.
    input wire logic CRYSTAL_CLK_OUT, // Crystal out.
    input wire logic BASE_CLK_OUT, // Base out.
    input wire logic CLKGEN_IRQ_OUT, // Loop irq.
    input wire logic VCO_LOOP_ON_OUT, // Loop on.
    input wire logic S_AXI_AWVALID, // Bus.
    input wire logic S_AXI_AWREADY, // Bus.
    input wire logic S_AXI_WVALID, // Bus.
    input wire logic S_AXI_WREADY, // Bus.
    input wire logic S_AXI_BVALID, // Bus.
    input wire logic S_AXI_BREADY, // Bus.
    input wire logic S_AXI_ARVALID, // Bus.
    input wire logic S_AXI_ARREADY, // Bus.
    input wire logic S_AXI_RVALID // Bus.
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    // Stop held for two edges must have silenced the base and crystal outputs.
    sequence s_held_stop;
        STOP_IN ##1 STOP_IN;
    endsequence
    sequence s_wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    AST_STOP_IRQ_LOW: assert property (STOP_IN |-> !CLKGEN_IRQ_OUT)
        else $error("Loop interrupt high in stop.");
    AST_STOP_NEXT_LOW: assert property (STOP_IN |=> !CRYSTAL_CLK_OUT && !BASE_CLK_OUT)
        else $error("Clock output high after stop.");
    AST_STOP_HELD: assert property (s_held_stop |-> !BASE_CLK_OUT && !CRYSTAL_CLK_OUT)
        else $error("Outputs not low in held stop.");
    AST_XTAL_FOLLOW: assert property (!STOP_IN |=> CRYSTAL_CLK_OUT == $past(XTAL_CLK_IN))
        else $error("Crystal output does not follow crystal.");
    // Loop enable moves only with a register write.
    AST_LOOP_ON_STABLE: assert property ($changed(VCO_LOOP_ON_OUT)
        |-> S_AXI_BVALID || $past(S_AXI_BVALID))
        else $error("Loop enable changed without a write.");
    AST_WR_LATENCY: assert property (s_wr_take |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("Write response not two cycles late.");
    AST_RD_LATENCY: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("Read data not one cycle late.");
    AST_B_DONE: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("Write response held after handshake.");
endmodule
bind plcb_top plcb_chk plcb_chk_i (.*);
`default_nettype wire

// File: verif/plcb_far_model.sv
// Core, break module and oscillators beside the clock block.
`timescale 1ns/10ps
`default_nettype none
module plcb_far_model (
    input wire logic clk_in, // System clock.
    input wire logic rst_in, // Reset, high.
    input wire logic [3:0] mode_in, // Stop, wait, break, clear enable.
    output logic xtal_out, // Crystal level, period 8 cycles.
    output logic vco_out, // VCO level, period 6 cycles.
    output logic stop_out, // Stop state.
    output logic wait_out, // Wait state.
    output logic brk_out, // Break state.
    output logic break_clear_enable_out // Break clear enable.
);
    logic [2:0] xc, vc;
    // Oscillators run slower than half the system clock so sampling sees each level;
    // core and break states change only at a clock edge, as the core would.
    always_ff @(posedge clk_in) begin
        stop_out <= mode_in[0];
        wait_out <= mode_in[1];
        brk_out <= mode_in[2];
        break_clear_enable_out <= mode_in[3];
        if (rst_in) begin
            xc <= 3'h0;
            vc <= 3'h0;
            xtal_out <= 1'b0;
            vco_out <= 1'b0;
        end else begin
            xc <= (xc == 3'h3) ? 3'h0 : xc + 3'h1;
            vc <= (vc == 3'h2) ? 3'h0 : vc + 3'h1;
            if (xc == 3'h3) xtal_out <= ~xtal_out;
            if (vc == 3'h2) vco_out <= ~vco_out;
        end
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench of the clock block.
`timescale 1ns/10ps
`default_nettype none
`include "plcb_regs.svh"
module tb;
    localparam a_ctl = `PLCB_OFF_LOOP_CTRL, a_bw = `PLCB_OFF_LOOP_BW, a_st = `PLCB_OFF_IRQ_STAT;
    localparam a_en = `PLCB_OFF_IRQ_EN, a_clr = `PLCB_OFF_IRQ_CLR;
    logic clk = 1'b0, rst = 1'b1, tracking_mode_flag = 1'b0, lck = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0] bresp, rresp;
    logic xt, vc, stp, wt, brk, bce, cx, bo, ci, lo, irq, awr, wr, br, arr, rv, pb;
    int n_fail = 0, samples_checked = 0, n;
    always #25 clk = ~clk;
    plcb_far_model plcb_far_model_i (.clk_in(clk), .rst_in(rst), .mode_in(mode), .xtal_out(xt),
        .vco_out(vc), .stop_out(stp), .wait_out(wt), .brk_out(brk), .break_clear_enable_out(bce));
    plcb_top plcb_top_i (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .XTAL_CLK_IN(xt), .VCO_CLK_IN(vc),
        .STOP_IN(stp), .WAIT_IN(wt), .BREAK_IN(brk), .BREAK_CLEAR_EN_IN(bce), .ACQ_DONE_IN(tracking_mode_flag),
        .LOCK_MET_IN(lck), .CRYSTAL_CLK_OUT(cx), .BASE_CLK_OUT(bo), .CLKGEN_IRQ_OUT(ci),
        .VCO_LOOP_ON_OUT(lo), .IRQ_OUT(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(br), .S_AXI_BREADY(1'b1),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));
    // Four-state compare so an unknown never matches.
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // Each channel is released at its own handshake edge.
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        fork
            begin
                do @(posedge clk); while (awr !== 1'b1);
                awv <= 1'b0;
            end
            begin
                do @(posedge clk); while (wr !== 1'b1);
                wv <= 1'b0;
            end
        join
        do @(posedge clk); while (br !== 1'b1);
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        chk($sformatf("read %h", a), e, rdat);
    endtask
    task automatic test_done();
        $display("Checks %0d, errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog far above the few hundred cycles the tests take.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("loop on", 32'h1, {31'h0, lo});
        rdc(a_ctl, 32'h2f);
        rdc(a_bw, 32'h00);
        rdc(8'h20, 32'h0);
        chk("rresp", 32'h2, {30'h0, rresp});
        wrr(a_ctl, 32'h00);
        wrr(a_ctl, 32'h10);
        rdc(a_ctl, 32'h0f);
        wrr(a_ctl, 32'h20);
        wrr(a_ctl, 32'h30);
        wrr(a_ctl, 32'h10);
        rdc(a_ctl, 32'h3f);
        mode <= 4'h2;
        repeat (20) @(posedge clk);
        chk("loop on in wait", 32'h1, {31'h0, lo});
        rdc(a_ctl, 32'h3f);
        wrr(a_en, 32'h07);
        wrr(a_bw, 32'h80);
        wrr(a_ctl, 32'hb0);
        tracking_mode_flag <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(a_bw, 32'ha0);
        rdc(a_st, 32'h01);
        lck <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(a_bw, 32'he0);
        chk("loop irq", 32'h1, {31'h0, ci});
        chk("irq", 32'h1, {31'h0, irq});
        mode <= 4'h6;
        repeat (2) @(posedge clk);
        rdc(a_ctl, 32'hff);
        wrr(a_ctl, 32'hb0);
        rdc(a_ctl, 32'hff);
        wrr(a_clr, 32'h03);
        rdc(a_st, 32'h03);
        mode <= 4'he;
        repeat (2) @(posedge clk);
        rdc(a_ctl, 32'hff);
        rdc(a_ctl, 32'hbf);
        wrr(a_clr, 32'h03);
        mode <= 4'h2;
        repeat (4) @(posedge clk);
        rdc(a_st, 32'h00);
        rdc(a_ctl, 32'hbf);
        chk("loop irq clear", 32'h0, {31'h0, ci});
        lck <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(a_bw, 32'ha0);
        chk("loop irq on loss", 32'h1, {31'h0, ci});
        chk("irq idle", 32'h0, {31'h0, irq});
        mode <= 4'h3;
        repeat (4) @(posedge clk);
        chk("stopped outputs", 32'h0, {29'h0, cx, bo, ci});
        mode <= 4'h0;
        repeat (2) @(posedge clk);
        rdc(a_ctl, 32'hef);
        rdc(a_st, 32'h04);
        chk("irq raised", 32'h1, {31'h0, irq});
        wrr(a_en, 32'h00);
        chk("irq masked", 32'h0, {31'h0, irq});
        wrr(a_clr, 32'h04);
        rdc(a_st, 32'h00);
        // Crystal halved: one base edge per crystal rise, 20 in 160 cycles.
        n = 0;
        pb = bo;
        repeat (160) begin
            @(posedge clk);
            if (bo !== pb) n++;
            pb = bo;
        end
        chk("base edges near 20", 32'h1, {31'h0, n >= 19 && n <= 21});
        rdc(a_ctl, 32'haf);
        wrr(a_ctl, 32'h30);
        wrr(a_ctl, 32'h20);
        wrr(a_ctl, 32'h00);
        rdc(a_ctl, 32'h0f);
        test_done();
    end
endmodule
`default_nettype wire
